/* File: logic/dcir_pkg.sv */
// Constants shared by the dual-core interrupt router.
`default_nettype none
package dcir_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 71;
  localparam int NUM_SHARED = 67;
  localparam int NUM_VIEW = 69;
  localparam int NUM_OUT = 26;
  localparam int NUM_CORE = 2;
  localparam int SEL_W = 5;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 12;
  localparam int CORE_PRO = 0;
  localparam int CORE_APP = 1;
  // ----------------------------------------------------------------
  // Source numbering
  // ----------------------------------------------------------------
  localparam int PIN_IRQ_NUM = 22;
  localparam int PIN_NMI_NUM = 23;
  localparam int APP_PIN_IRQ_IN = 69;
  localparam int APP_PIN_NMI_IN = 70;
  // ----------------------------------------------------------------
  // Selector encoding and reset values
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_LIMIT = 5'h1A;
  localparam logic [SEL_W-1:0] SEL_NONE = 5'h1F;
  localparam logic [NUM_OUT-1:0] OUT_BIT0 = 26'h0000001;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] MAP_PRO_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] MAP_APP_BASE = 12'h200;
  localparam logic [ADDR_W-1:0] STAT_PRO_LOW = 12'h400;
  localparam logic [ADDR_W-1:0] STAT_PRO_MID = 12'h404;
  localparam logic [ADDR_W-1:0] STAT_PRO_HIGH = 12'h408;
  localparam logic [ADDR_W-1:0] STAT_APP_LOW = 12'h40C;
  localparam logic [ADDR_W-1:0] STAT_APP_MID = 12'h410;
  localparam logic [ADDR_W-1:0] STAT_APP_HIGH = 12'h414;
  localparam logic [ADDR_W-1:0] EVT_STAT_OFF = 12'h418;
  localparam logic [ADDR_W-1:0] EVT_MASK_OFF = 12'h41C;
  // Field positions inside a mapping-register address and of the mid and high status words.
  localparam int MAP_CORE_BIT = 9;
  localparam int MAP_IDX_LSB = 2;
  localparam int MAP_IDX_MSB = 8;
  localparam int MAP_REGION_LSB = 10;
  localparam int MID_LSB = 32;
  localparam int HIGH_LSB = 64;
endpackage
`default_nettype wire

/* File: logic/dcir_router.sv */
// Dual-core interrupt router with its APB register slave.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - There are 71 peripheral request inputs, each with a fixed number.
// - 67 shared sources route to either core, with a setting per core.
// - The two pin interrupts of each core reach only that core.
// - Each core therefore sees 69 routable sources.
// - In each core's first status word, source n (0 to 31) is bit n.
// - Each core gets 26 interrupt outputs, 52 in all.
module dcir_router (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [dcir_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [dcir_pkg::WORD_W-1:0] pwdata_i,
  output logic [dcir_pkg::WORD_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Peripheral sources
  input wire logic [dcir_pkg::NUM_SRC-1:0] src_irq_i,
  // Core interrupt outputs
  output logic [dcir_pkg::NUM_OUT-1:0] pro_irq_o,
  output logic [dcir_pkg::NUM_OUT-1:0] app_irq_o,
  // Block interrupt
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Per-core source views and routing state.
  logic [dcir_pkg::NUM_VIEW-1:0] view [dcir_pkg::NUM_CORE];
  logic [dcir_pkg::NUM_VIEW-1:0] unrouted [dcir_pkg::NUM_CORE];
  logic [dcir_pkg::NUM_OUT-1:0] hot [dcir_pkg::NUM_CORE][dcir_pkg::NUM_VIEW];
  logic [dcir_pkg::SEL_W-1:0] map_reg [dcir_pkg::NUM_CORE][dcir_pkg::NUM_VIEW];
  logic [dcir_pkg::SEL_W-1:0] map_next [dcir_pkg::NUM_CORE][dcir_pkg::NUM_VIEW];
  logic [dcir_pkg::NUM_OUT-1:0] out_reg [dcir_pkg::NUM_CORE];
  logic [dcir_pkg::NUM_OUT-1:0] out_next [dcir_pkg::NUM_CORE];
  // Event detection, status, mask and block interrupt.
  logic [dcir_pkg::NUM_CORE-1:0] stray;
  logic [dcir_pkg::NUM_CORE-1:0] stray_reg;
  logic [dcir_pkg::NUM_CORE-1:0] evt_reg;
  logic [dcir_pkg::NUM_CORE-1:0] evt_next;
  logic [dcir_pkg::NUM_CORE-1:0] mask_reg;
  logic [dcir_pkg::NUM_CORE-1:0] mask_next;
  logic irq_reg;
  logic irq_next;
  // Register bus state and decode.
  logic [dcir_pkg::WORD_W-1:0] rdata_reg;
  logic [dcir_pkg::WORD_W-1:0] rdata_next;
  logic err_reg;
  logic err_next;
  logic setup;
  logic access;
  logic map_hit;
  logic map_core;
  logic [dcir_pkg::MAP_IDX_MSB-dcir_pkg::MAP_IDX_LSB:0] map_idx;
  // Side-effect strobes, all taken at the access edge.
  logic map_wr;
  logic mask_wr;
  logic evt_rd;

  // ----------------------------------------------------------------
  // Source views and selector decode
  // ----------------------------------------------------------------
  // The app core's pin pair arrives on its own inputs but occupies the
  // same source numbers in the app view as the protocol pair does in the
  // protocol view, so the two pairs can never cross cores.
  genvar gc;
  genvar gn;
  generate
    for (gc = 0; gc < dcir_pkg::NUM_CORE; gc++) begin : g_core
      for (gn = 0; gn < dcir_pkg::NUM_VIEW; gn++) begin : g_src
        if (gc == dcir_pkg::CORE_APP && gn == dcir_pkg::PIN_IRQ_NUM) begin : g_ai
          assign view[gc][gn] = src_irq_i[dcir_pkg::APP_PIN_IRQ_IN];
        end else if (gc == dcir_pkg::CORE_APP &&
                     gn == dcir_pkg::PIN_NMI_NUM) begin : g_an
          assign view[gc][gn] = src_irq_i[dcir_pkg::APP_PIN_NMI_IN];
        end else begin : g_sh
          assign view[gc][gn] = src_irq_i[gn];
        end
        assign unrouted[gc][gn] = map_reg[gc][gn] >= dcir_pkg::SEL_LIMIT;
        assign hot[gc][gn] = (view[gc][gn] && !unrouted[gc][gn]) ?
          (dcir_pkg::OUT_BIT0 << map_reg[gc][gn]) : '0;
      end
      assign stray[gc] = |(view[gc] & unrouted[gc]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output merge
  // ----------------------------------------------------------------
  // Several sources may share one output. The lines are a plain OR, so a
  // core must read its status view to tell the sharers apart.
  // Registering the merge costs one cycle of latency but keeps the core
  // inputs free of decode glitches while selectors change.
  always_comb begin
    for (int c = 0; c < dcir_pkg::NUM_CORE; c++) begin
      out_next[c] = '0;
      for (int n = 0; n < dcir_pkg::NUM_VIEW; n++) begin
        out_next[c] = out_next[c] | hot[c][n];
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int c = 0; c < dcir_pkg::NUM_CORE; c++) begin
        out_reg[c] <= '0;
      end
    end else begin
      for (int c = 0; c < dcir_pkg::NUM_CORE; c++) begin
        out_reg[c] <= out_next[c];
      end
    end
  end

  assign pro_irq_o = out_reg[dcir_pkg::CORE_PRO];
  assign app_irq_o = out_reg[dcir_pkg::CORE_APP];

  // ----------------------------------------------------------------
  // APB decode and read path
  // ----------------------------------------------------------------
  // Mapping registers take one word per source, and the core bit picks
  // the bank. Anything outside the map and the status block answers with
  // a slave error instead of silently aliasing.
  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i;
  assign map_core = paddr_i[dcir_pkg::MAP_CORE_BIT];
  assign map_idx = paddr_i[dcir_pkg::MAP_IDX_MSB:dcir_pkg::MAP_IDX_LSB];
  assign map_hit = (paddr_i[dcir_pkg::ADDR_W-1:dcir_pkg::MAP_REGION_LSB]
                    == '0) &&
                   (paddr_i[dcir_pkg::MAP_IDX_LSB-1:0] == '0) &&
                   (map_idx < dcir_pkg::NUM_VIEW);

  // Read data is sampled in the setup cycle, so the access phase always
  // completes in one cycle and prdata comes straight from a flop.
  always_comb begin
    rdata_next = rdata_reg;
    err_next = err_reg;
    if (setup) begin
      rdata_next = '0;
      err_next = 1'b0;
      if (map_hit) begin
        rdata_next[dcir_pkg::SEL_W-1:0] = map_reg[map_core][map_idx];
      end else begin
        // Source status words show live source levels; nothing is latched, so a
        // pulse shorter than a bus transfer may never be seen here.
        unique case (paddr_i)
          dcir_pkg::STAT_PRO_LOW:
            rdata_next =
              view[dcir_pkg::CORE_PRO][dcir_pkg::MID_LSB-1:0];
          dcir_pkg::STAT_PRO_MID:
            rdata_next = view[dcir_pkg::CORE_PRO]
              [dcir_pkg::HIGH_LSB-1:dcir_pkg::MID_LSB];
          dcir_pkg::STAT_PRO_HIGH:
            rdata_next[dcir_pkg::NUM_VIEW-dcir_pkg::HIGH_LSB-1:0] =
              view[dcir_pkg::CORE_PRO]
              [dcir_pkg::NUM_VIEW-1:dcir_pkg::HIGH_LSB];
          dcir_pkg::STAT_APP_LOW:
            rdata_next =
              view[dcir_pkg::CORE_APP][dcir_pkg::MID_LSB-1:0];
          dcir_pkg::STAT_APP_MID:
            rdata_next = view[dcir_pkg::CORE_APP]
              [dcir_pkg::HIGH_LSB-1:dcir_pkg::MID_LSB];
          dcir_pkg::STAT_APP_HIGH:
            rdata_next[dcir_pkg::NUM_VIEW-dcir_pkg::HIGH_LSB-1:0] =
              view[dcir_pkg::CORE_APP]
              [dcir_pkg::NUM_VIEW-1:dcir_pkg::HIGH_LSB];
          dcir_pkg::EVT_STAT_OFF:
            rdata_next[dcir_pkg::NUM_CORE-1:0] = evt_reg;
          dcir_pkg::EVT_MASK_OFF:
            rdata_next[dcir_pkg::NUM_CORE-1:0] = mask_reg;
          default:
            err_next = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_reg <= '0;
      err_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  assign prdata_o = rdata_reg;
  assign pslverr_o = access && err_reg;
  assign pready_o = access;

  // ----------------------------------------------------------------
  // Write and clear strobes
  // ----------------------------------------------------------------
  // Every register side effect waits for the access edge. A status read
  // may clear only what it has returned, and that value is known only
  // once the setup edge has sampled it.
  assign map_wr = access &&
                  pwrite_i &&
                  map_hit;
  assign mask_wr = access &&
                   pwrite_i &&
                   !err_reg &&
                   (paddr_i == dcir_pkg::EVT_MASK_OFF);
  assign evt_rd = access &&
                  !pwrite_i &&
                  (paddr_i == dcir_pkg::EVT_STAT_OFF);

  // ----------------------------------------------------------------
  // Routing registers
  // ----------------------------------------------------------------
  // Selector bits above the field are dropped on write, and codes from
  // the limit upwards park the source. Reset parks every source so that
  // nothing reaches a core before software has routed it.
  always_comb begin
    map_next = map_reg;
    if (map_wr) begin
      map_next[map_core][map_idx] = pwdata_i[dcir_pkg::SEL_W-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int c = 0; c < dcir_pkg::NUM_CORE; c++) begin
        for (int n = 0; n < dcir_pkg::NUM_VIEW; n++) begin
          map_reg[c][n] <= dcir_pkg::SEL_NONE;
        end
      end
    end else begin
      map_reg <= map_next;
    end
  end

  // ----------------------------------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------------------------------
  // An event is a rise of the OR of the active unrouted sources on that core. Only
  // the bits returned by the read are cleared, and a new event in the
  // clearing cycle still sets its bit.
  always_comb begin
    mask_next = mask_reg;
    evt_next = evt_reg;
    if (mask_wr) begin
      mask_next = pwdata_i[dcir_pkg::NUM_CORE-1:0];
    end
    if (evt_rd) begin
      evt_next = evt_next & ~rdata_reg[dcir_pkg::NUM_CORE-1:0];
    end
    evt_next = evt_next | (stray & ~stray_reg);
    // The interrupt is computed from the next values so that it rises
    // together with the status bit rather than one cycle after it.
    irq_next = |(evt_next & mask_next);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      stray_reg <= '0;
      evt_reg <= '0;
      mask_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      stray_reg <= stray;
      evt_reg <= evt_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
    end
  end

  assign irq_o = irq_reg;

endmodule // dcir_router
`default_nettype wire

/* File: verif/dcir_core_model.sv */
// Behavioural pair of cores that latch their routed interrupt lines.
`timescale 1ns/10ps
`default_nettype none
module dcir_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Routed lines in, latched view out
  input wire logic [25:0] pro_irq_i,
  input wire logic [25:0] app_irq_i,
  output logic [25:0] pro_seen_o,
  output logic [25:0] app_seen_o
);
  // Each core samples its 26 lines once per clock.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pro_seen_o <= '0;
      app_seen_o <= '0;
    end else begin
      pro_seen_o <= pro_irq_i;
      app_seen_o <= app_irq_i;
    end
  end
endmodule // dcir_core_model
`default_nettype wire

/* File: verif/dcir_router_checker.sv */
// Port-level assertions for the dual-core interrupt router.
`timescale 1ns/10ps
`default_nettype none
module dcir_router_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Bus and lines
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [70:0] src_irq_i,
  input wire logic [25:0] pro_irq_o,
  input wire logic [25:0] app_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire logic rd = psel_i && penable_i && !pwrite_i;
  property p_rdy; psel_i && penable_i |-> pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_err; psel_i && penable_i && paddr_i == 12'hFFC |-> pslverr_o;
  endproperty
  a_err: assert property (p_err) else $error("no slave error");
  property p_elen; pslverr_o |-> psel_i && penable_i; endproperty
  a_elen: assert property (p_elen) else $error("stray error");
  property p_plo; rd && paddr_i == 12'h400
    |-> !pslverr_o && prdata_o == $past(src_irq_i[31:0]); endproperty
  a_plo: assert property (p_plo) else $error("pro low view");
  property p_alo; rd && paddr_i == 12'h40C |-> prdata_o ==
    {$past(src_irq_i[31:24]), $past(src_irq_i[70:69]),
     $past(src_irq_i[21:0])}; endproperty
  a_alo: assert property (p_alo) else $error("app low view");
  property p_phi; rd && paddr_i == 12'h408
    |-> prdata_o == {27'h0, $past(src_irq_i[68:64])}; endproperty
  a_phi: assert property (p_phi) else $error("pro high view");
  property p_amd; rd && paddr_i == 12'h410
    |-> prdata_o == $past(src_irq_i[63:32]); endproperty
  a_amd: assert property (p_amd) else $error("app mid view");
  property p_rst; $fell(reset_i) |-> pro_irq_o == 0 && app_irq_o == 0;
  endproperty
  a_rst: assert property (p_rst) else $error("lines after reset");
  property p_idle; src_irq_i == 0 [*2] |=> pro_irq_o == 0 && app_irq_o == 0;
  endproperty
  a_idle: assert property (p_idle) else $error("line w/o source");
  c_rd: cover property (rd && paddr_i == 12'h400);
  c_err: cover property (pslverr_o);
  c_rt: cover property (|pro_irq_o && |app_irq_o);
endmodule // dcir_router_checker
bind dcir_router dcir_router_checker u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .src_irq_i(src_irq_i),
  .pro_irq_o(pro_irq_o), .app_irq_o(app_irq_o));
`default_nettype wire

/* File: verif/dcir_router_tb.sv */
// Self-checking testbench for the dual-core interrupt router.
`timescale 1ns/10ps
`default_nettype none
module dcir_router_tb;
  logic clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic irq_o, er;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [70:0] src_irq_i, s;
  logic [25:0] pro_irq_o, app_irq_o, pro_seen, app_seen;
  logic [15:0] seed;
  int error_cnt, n_tests;
  dcir_router u_dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .src_irq_i(src_irq_i), .pro_irq_o(pro_irq_o),
    .app_irq_o(app_irq_o), .irq_o(irq_o));
  dcir_core_model u_cores (.clk_i(clk_i), .reset_i(reset_i),
    .pro_irq_i(pro_irq_o), .app_irq_i(app_irq_o), .pro_seen_o(pro_seen),
    .app_seen_o(app_seen));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // The application pin pair enters on 69/70 but shows as sources 22/23.
  function automatic logic [31:0] app_low(input logic [70:0] v);
    return {v[31:24], v[70:69], v[21:0]};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1) error_cnt++;
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    #(50 * 4000);
    error_cnt++;
    stop_test;
  end
  initial begin
    {reset_i, psel_i, penable_i, pwrite_i} = 4'h8;
    paddr_i = 12'h0;
    pwdata_i = 32'h0;
    src_irq_i = '0;
    s = '0;
    seed = 16'h7422;
    error_cnt = 0;
    n_tests = 0;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    rchk(12'h000, 32'h1F);
    rchk(12'h41C, 32'h0);
    rchk(12'hFFC, 32'h0);
    chk({31'h0, er}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      repeat (5) begin
        seed = lfsr(seed);
        s = {s[54:0], seed};
      end
      if (i == 0) s = '1;
      src_irq_i <= s;
      rchk(12'h400, s[31:0]);
      rchk(12'h40C, app_low(s));
      rchk(12'h408, {27'h0, s[68:64]});
    end
    src_irq_i <= '0;
    apb(1'b0, 12'h418, 32'h0);
    apb(1'b1, 12'h014, 32'h3);
    apb(1'b1, 12'h214, 32'h19);
    apb(1'b1, 12'h058, 32'h0);
    apb(1'b1, 12'h258, 32'h1);
    apb(1'b1, 12'h000, 32'hFFFFFFE2);
    src_irq_i <= (71'h1 << 69) | (71'h1 << 22) | 71'h21;
    repeat (4) @(posedge clk_i);
    chk({6'h0, pro_seen}, 32'hD);
    chk({6'h0, app_seen}, 32'h2000002);
    src_irq_i <= '0;
    apb(1'b0, 12'h418, 32'h0);
    apb(1'b1, 12'h41C, 32'h1);
    apb(1'b1, 12'h014, 32'h1A);
    src_irq_i <= 71'h20;
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    rchk(12'h418, 32'h1);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    stop_test;
  end
endmodule // dcir_router_tb
`default_nettype wire
